// ==== logic/intc_pkg.sv ====
// shared constants, offsets and types for the interrupt acceptance block
package intc_pkg;
	// ----------------------------------------
	// levels and sizes
	// ----------------------------------------
	localparam logic [2:0] MASK_RESET = 3'h7;
	localparam logic [2:0] LEVEL_NMI = 3'h7;
	localparam logic [2:0] LEVEL_DMA = 3'h6;
	localparam logic [2:0] LEVEL_OFF = 3'h0;
	localparam logic [2:0] LEVEL_MIN = 3'h1;
	localparam int NUM_PIN = 8;
	localparam int NUM_CH = 8;
	localparam int NUM_SRC = 16;
	localparam int STACK_DEPTH = 16;
	localparam int VTAB_WORDS = 64;
	// ----------------------------------------
	// vector area and vector values
	// ----------------------------------------
	localparam logic [23:0] VECTOR_BASE = 24'hffff00;
	localparam logic [23:0] VECTOR_TOP = 24'hffffff;
	localparam int VECTOR_AREA_BYTES = 256;
	localparam logic [7:0] VEC_ILLEGAL = 8'h08;
	localparam logic [7:0] VEC_NMI = 8'h20;
	localparam logic [7:0] VEC_PIN0 = 8'h28;
	localparam logic [7:0] VEC_TC0 = 8'hd0;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [8:0] ADDR_PRIO_PIN = 9'h000;
	localparam logic [8:0] ADDR_PRIO_TC = 9'h004;
	localparam logic [8:0] ADDR_CMD = 9'h008;
	localparam logic [8:0] ADDR_PC = 9'h00c;
	localparam logic [8:0] ADDR_SR = 9'h010;
	localparam logic [8:0] ADDR_SSP = 9'h014;
	localparam logic [8:0] ADDR_PENDING = 9'h018;
	localparam logic [8:0] ADDR_SOFT_DMA = 9'h01c;
	localparam logic [8:0] ADDR_CH_BASE = 9'h040;
	localparam logic [8:0] ADDR_VTAB = 9'h100;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PRIO_STRIDE = 4;
	localparam int CMD_OP_LSB = 4;
	localparam int STAT_BUSY_BIT = 4;
	localparam int STAT_HOLD_BIT = 5;
	localparam int STAT_NEST_LSB = 8;
	localparam int SR_MASK_LSB = 12;
	localparam int CH_SIZE_LSB = 8;
	localparam int CH_COUNT_LSB = 16;
	localparam int PEND_NMI_BIT = 16;
	typedef enum logic [2:0] {
		OP_STEP,
		OP_SET_MASK,
		OP_BLOCK_MASKABLE,
		OP_SW_TRAP,
		OP_ILLEGAL,
		OP_RETURN
	} cmd_op_t;
endpackage

// ==== logic/level_resolver.sv ====
// picks the highest pending level, smallest index on a tie
`timescale 1ns/1ps
module level_resolver
	import intc_pkg::*;
(
	input wire logic [NUM_SRC-1:0] request,
	input wire logic [3*NUM_SRC-1:0] levels,
	output logic [2:0] best_level,
	output logic [3:0] best_index
);
	// walking downward lets the smaller index win a tie
	always_comb begin
		logic [2:0] lv;
		lv = LEVEL_OFF;
		best_level = LEVEL_OFF;
		best_index = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			lv = levels[3*i +: 3];
			if (request[i] && lv != LEVEL_OFF && lv >= best_level) begin
				best_level = lv;
				best_index = 4'(i);
			end
		end
	end
endmodule

// ==== logic/priority_interrupt_acceptance.sv ====
// interrupt controller with core acceptance sequencer and transfer channels
`timescale 1ns/1ps
module priority_interrupt_acceptance
	import intc_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [8:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	input wire logic [NUM_PIN-1:0] EXTERNAL_REQUEST_PINS,
	input wire logic NMI_PIN,
	output logic [2:0] PRESENT_LEVEL,
	output logic HANDLER_START,
	output logic [23:0] VECTOR_FETCH_ADDR,
	output logic [23:0] HANDLER_PC,
	output logic DMA_XFER,
	output logic [2:0] DMA_CHANNEL,
	output logic [2:0] DMA_BYTES
);
	typedef enum {S_IDLE, S_VECTOR, S_PUSH, S_MASK, S_BRANCH, S_DMA} state_t;

	function automatic logic [7:0] vec_of(input logic [3:0] idx);
		logic [7:0] off;
		off = {3'h0, idx[2:0], 2'h0};
		return idx[3] ? VEC_TC0 + off : VEC_PIN0 + off;
	endfunction

	function automatic logic [2:0] valid_level(input logic [2:0] p);
		return (p == LEVEL_OFF || p == LEVEL_NMI) ? LEVEL_OFF : p;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [NUM_PIN:0] pin_s1, pin_s2, pin_s3, pin_stable;
	logic [NUM_PIN:0] pin_rise;
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_stable <= '0;
		end else begin
			pin_s1 <= {NMI_PIN, EXTERNAL_REQUEST_PINS};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
		end
	end
	assign pin_rise = pin_s2 & pin_s3 & ~pin_stable;

	// ----------------------------------------
	// state shared across sections
	// ----------------------------------------
	state_t state;
	logic [NUM_SRC-1:0] pending, vec_clr;
	logic [NUM_CH-1:0] tc_set;
	logic nmi_pend;
	logic [2:0] prio [0:NUM_SRC-1];
	logic [7:0] ch_vec [0:NUM_CH-1];
	logic [1:0] ch_size [0:NUM_CH-1];
	logic [15:0] ch_count [0:NUM_CH-1];
	logic [NUM_CH-1:0] soft_req;
	logic [2:0] mask_level, acc_level, acc_ch, res_level, present_level;
	logic [3:0] res_idx, dma_src_idx, ssp;
	logic [7:0] acc_vec, nesting;
	logic [23:0] pc;
	logic [15:0] sr;
	logic [39:0] stack_mem [0:STACK_DEPTH-1];
	logic [23:0] vtab [0:VTAB_WORDS-1];
	logic is_trap, acc_nmi, sample_hold, ack;
	logic [NUM_SRC-1:0] routed;
	logic [NUM_CH-1:0] ch_req;
	logic [3*NUM_SRC-1:0] eff_levels;
	logic dma_any, dma_src_hit, take_irq, take_dma;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic req, is_cmd_wr, ack_ok, wr_commit, cmd_commit, ch_sel, vt_sel;
	cmd_op_t cmd_op;
	logic [2:0] cmd_arg;
	assign req = READ | WRITE;
	assign is_cmd_wr = WRITE && ADDRESS == ADDR_CMD;
	// commands wait while a sequence runs, so traps never overlap one
	assign ack_ok = !is_cmd_wr || (state == S_IDLE && !take_irq);
	assign WAITREQUEST = req & ~ack;
	assign wr_commit = ack & WRITE;
	assign cmd_commit = ack & is_cmd_wr;
	assign cmd_op = cmd_op_t'(WRITEDATA[CMD_OP_LSB +: 3]);
	assign cmd_arg = WRITEDATA[2:0];
	assign ch_sel = ADDRESS[8:5] == ADDR_CH_BASE[8:5];
	assign vt_sel = ADDRESS[8] == ADDR_VTAB[8];

	// ----------------------------------------
	// routing and arbitration
	// ----------------------------------------
	always_comb begin
		routed = '0;
		ch_req = soft_req;
		for (int c = 0; c < NUM_CH; c++) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				if (ch_vec[c] != 8'h00 && ch_vec[c] == vec_of(4'(i))) begin
					routed[i] = 1'b1;
					ch_req[c] = ch_req[c] | pending[i];
				end
			end
		end
		for (int i = 0; i < NUM_SRC; i++) begin
			eff_levels[3*i +: 3] = routed[i] ? LEVEL_DMA : valid_level(prio[i]);
		end
	end

	assign dma_any = |ch_req;
	// lowest channel first, independent of levels
	logic [2:0] dma_ch;
	always_comb begin
		dma_ch = 3'h0;
		for (int c = NUM_CH - 1; c >= 0; c--) begin
			if (ch_req[c]) begin
				dma_ch = 3'(c);
			end
		end
		dma_src_hit = 1'b0;
		dma_src_idx = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i] && ch_vec[dma_ch] != 8'h00 && ch_vec[dma_ch] == vec_of(4'(i))) begin
				dma_src_hit = 1'b1;
				dma_src_idx = 4'(i);
			end
		end
	end

	level_resolver u_resolver (
		.request(pending),
		.levels(eff_levels),
		.best_level(res_level),
		.best_index(res_idx)
	);

	always_comb begin
		if (nmi_pend) begin
			present_level = LEVEL_NMI;
		end else if (soft_req != '0 && res_level < LEVEL_DMA) begin
			present_level = LEVEL_DMA;
		end else begin
			present_level = res_level;
		end
	end
	// preemption falls out of the compare against the raised mask
	assign take_irq = state == S_IDLE && !sample_hold && !cmd_commit && present_level != LEVEL_OFF && present_level >= mask_level;
	assign take_dma = take_irq && !nmi_pend && dma_any;

	// ----------------------------------------
	// request flags
	// ----------------------------------------
	always_comb begin
		vec_clr = '0;
		if (state == S_VECTOR && !nmi_pend) begin
			vec_clr[res_idx] = 1'b1;
		end
		if (take_dma && dma_src_hit) begin
			vec_clr[dma_src_idx] = 1'b1;
		end
	end
	// a new edge on the same cycle as the clear keeps the flag
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pending <= '0;
			nmi_pend <= 1'b0;
		end else begin
			pending <= (pending & ~vec_clr) | {tc_set, pin_rise[NUM_PIN-1:0]};
			nmi_pend <= pin_rise[NUM_PIN] | (nmi_pend & !(state == S_VECTOR));
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				prio[i] <= LEVEL_OFF;
			end
		end else if (wr_commit && ADDRESS == ADDR_PRIO_PIN) begin
			for (int i = 0; i < NUM_PIN; i++) begin
				prio[i] <= WRITEDATA[PRIO_STRIDE*i +: 3];
			end
		end else if (wr_commit && ADDRESS == ADDR_PRIO_TC) begin
			for (int i = 0; i < NUM_PIN; i++) begin
				prio[NUM_PIN+i] <= WRITEDATA[PRIO_STRIDE*i +: 3];
			end
		end
	end

	// ----------------------------------------
	// transfer channels
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			soft_req <= '0;
			tc_set <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				ch_vec[c] <= 8'h00;
				ch_size[c] <= 2'h0;
				ch_count[c] <= 16'h0000;
			end
		end else begin
			tc_set <= '0;
			if (wr_commit && ADDRESS == ADDR_SOFT_DMA) begin
				soft_req <= soft_req | WRITEDATA[NUM_CH-1:0];
			end else if (take_dma) begin
				soft_req[dma_ch] <= 1'b0;
			end
			if (wr_commit && ch_sel) begin
				ch_vec[ADDRESS[4:2]] <= WRITEDATA[7:0];
				ch_size[ADDRESS[4:2]] <= WRITEDATA[CH_SIZE_LSB +: 2];
				ch_count[ADDRESS[4:2]] <= WRITEDATA[CH_COUNT_LSB +: 16];
			end else if (state == S_DMA) begin
				ch_count[acc_ch] <= ch_count[acc_ch] - 16'h0001;
				if (ch_count[acc_ch] == 16'h0001) begin
					ch_vec[acc_ch] <= 8'h00;
					tc_set[acc_ch] <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// acceptance sequencer
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state <= S_IDLE;
			is_trap <= 1'b0;
			acc_nmi <= 1'b0;
			acc_vec <= 8'h00;
			acc_level <= LEVEL_OFF;
			acc_ch <= 3'h0;
		end else begin
			case (state)
				S_IDLE: begin
					if (take_dma) begin
						acc_ch <= dma_ch;
						state <= S_DMA;
					end else if (take_irq) begin
						is_trap <= 1'b0;
						state <= S_VECTOR;
					end else if (cmd_commit && cmd_op == OP_SW_TRAP) begin
						is_trap <= 1'b1;
						acc_vec <= {3'h0, cmd_arg, 2'h0};
						state <= S_PUSH;
					end else if (cmd_commit && cmd_op == OP_ILLEGAL) begin
						is_trap <= 1'b1;
						acc_vec <= VEC_ILLEGAL;
						state <= S_PUSH;
					end
				end
				S_VECTOR: begin
					acc_nmi <= nmi_pend;
					acc_vec <= nmi_pend ? VEC_NMI : vec_of(res_idx);
					acc_level <= nmi_pend ? LEVEL_NMI : res_level;
					state <= S_PUSH;
				end
				S_PUSH: state <= S_MASK;
				S_MASK: state <= S_BRANCH;
				S_BRANCH: state <= S_IDLE;
				S_DMA: state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	// the first instruction after entry runs before the next sampling
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			sample_hold <= 1'b0;
		end else if (state == S_BRANCH) begin
			sample_hold <= 1'b1;
		end else if (cmd_commit) begin
			sample_hold <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mask_level <= MASK_RESET;
		end else if (state == S_MASK && !is_trap) begin
			mask_level <= (acc_level == LEVEL_NMI) ? LEVEL_NMI : acc_level + 3'h1;
		end else if (cmd_commit && cmd_op == OP_SET_MASK) begin
			mask_level <= (cmd_arg == LEVEL_OFF) ? LEVEL_MIN : cmd_arg;
		end else if (cmd_commit && cmd_op == OP_BLOCK_MASKABLE) begin
			mask_level <= LEVEL_NMI;
		end else if (cmd_commit && cmd_op == OP_RETURN && ssp != 4'h0) begin
			mask_level <= stack_mem[ssp - 4'h1][SR_MASK_LSB +: 3];
		end
	end

	// ----------------------------------------
	// context, nesting and stack
	// ----------------------------------------
	logic [15:0] sr_view;
	logic pop;
	assign sr_view = {sr[15], mask_level, sr[11:0]};
	assign pop = cmd_commit && cmd_op == OP_RETURN && ssp != 4'h0;
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ssp <= 4'h0;
			nesting <= 8'h00;
			pc <= 24'h000000;
			sr <= 16'h0000;
		end else begin
			if (state == S_PUSH) begin
				stack_mem[ssp] <= {pc, sr_view};
				ssp <= ssp + 4'h1;
			end else if (pop) begin
				{pc, sr} <= stack_mem[ssp - 4'h1];
				ssp <= ssp - 4'h1;
			end
			if (state == S_MASK) begin
				nesting <= nesting + 8'h01;
			end else if (pop) begin
				nesting <= nesting - 8'h01;
			end
			if (state == S_BRANCH) begin
				pc <= vtab[acc_vec[7:2]];
			end else if (wr_commit && ADDRESS == ADDR_PC) begin
				pc <= WRITEDATA[23:0];
			end
			if (wr_commit && ADDRESS == ADDR_SR) begin
				sr <= WRITEDATA[15:0];
			end
		end
	end

	// one word per vector slot across the whole area
	always_ff @(posedge CLOCK) begin
		if (wr_commit && vt_sel) begin
			vtab[ADDRESS[7:2]] <= WRITEDATA[23:0];
		end
	end

	// ----------------------------------------
	// core-facing outputs
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PRESENT_LEVEL <= LEVEL_OFF;
			HANDLER_START <= 1'b0;
			VECTOR_FETCH_ADDR <= VECTOR_BASE;
			HANDLER_PC <= 24'h000000;
			DMA_XFER <= 1'b0;
			DMA_CHANNEL <= 3'h0;
			DMA_BYTES <= 3'h0;
		end else begin
			PRESENT_LEVEL <= present_level;
			HANDLER_START <= state == S_BRANCH;
			DMA_XFER <= state == S_DMA;
			if (state == S_BRANCH) begin
				VECTOR_FETCH_ADDR <= VECTOR_BASE + {16'h0000, acc_vec};
				HANDLER_PC <= vtab[acc_vec[7:2]];
			end
			if (state == S_DMA) begin
				DMA_CHANNEL <= acc_ch;
				DMA_BYTES <= (ch_size[acc_ch] == 2'h0) ? 3'h1 : (ch_size[acc_ch] == 2'h1) ? 3'h2 : 3'h4;
			end
		end
	end

	// ----------------------------------------
	// bus read path
	// ----------------------------------------
	logic [31:0] rd_value;
	always_comb begin
		rd_value = 32'h00000000;
		if (vt_sel) begin
			rd_value = {8'h00, vtab[ADDRESS[7:2]]};
		end else if (ch_sel) begin
			rd_value = {ch_count[ADDRESS[4:2]], 6'h00, ch_size[ADDRESS[4:2]], ch_vec[ADDRESS[4:2]]};
		end else begin
			case (ADDRESS)
				ADDR_CMD: rd_value = {16'h0000, nesting, 2'h0, sample_hold, state != S_IDLE, 1'b0, mask_level};
				ADDR_PC: rd_value = {8'h00, pc};
				ADDR_SR: rd_value = {16'h0000, sr_view};
				ADDR_SSP: rd_value = {28'h0000000, ssp};
				ADDR_PENDING: rd_value = {15'h0000, nmi_pend, pending};
				ADDR_SOFT_DMA: rd_value = {24'h000000, soft_req};
				default: rd_value = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ack <= 1'b0;
			READDATA <= 32'h00000000;
		end else begin
			ack <= req && !ack && ack_ok;
			if (READ && !ack && ack_ok) begin
				READDATA <= rd_value;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_mask_after_reset;
		@(posedge CLOCK) $fell(RST) |-> mask_level == 3'h7;
	endproperty
	a_mask_after_reset: assert property (p_mask_after_reset) else $error("mask not 7 after reset");

	property p_block_maskable;
		@(posedge CLOCK) disable iff (RST) cmd_commit && cmd_op == OP_BLOCK_MASKABLE |=> mask_level == 3'h7;
	endproperty
	a_block_maskable: assert property (p_block_maskable) else $error("block did not load seven");

	property p_take_level;
		@(posedge CLOCK) disable iff (RST) $rose(state == S_VECTOR) |-> $past(present_level) >= $past(mask_level) && $past(present_level) != 3'h0;
	endproperty
	a_take_level: assert property (p_take_level) else $error("accepted below mask");

	property p_mask_raise;
		@(posedge CLOCK) disable iff (RST) state == S_MASK && !is_trap |=> mask_level == (($past(acc_level) == 3'h7) ? 3'h7 : $past(acc_level) + 3'h1);
	endproperty
	a_mask_raise: assert property (p_mask_raise) else $error("mask not raised");

	property p_trap_keeps_mask;
		@(posedge CLOCK) disable iff (RST) state == S_MASK && is_trap |=> $stable(mask_level);
	endproperty
	a_trap_keeps_mask: assert property (p_trap_keeps_mask) else $error("trap changed mask");

	property p_entry_sequence;
		@(posedge CLOCK) disable iff (RST) state == S_PUSH |=> state == S_MASK ##1 state == S_BRANCH ##1 HANDLER_START && nesting == $past(nesting, 2) + 8'h01;
	endproperty
	a_entry_sequence: assert property (p_entry_sequence) else $error("bad entry sequence");

	property p_hold_blocks;
		@(posedge CLOCK) disable iff (RST) HANDLER_START |-> !take_irq throughout (sample_hold [*1]);
	endproperty
	a_hold_blocks: assert property (p_hold_blocks) else $error("sampled during hold");

	property p_vector_clears;
		@(posedge CLOCK) disable iff (RST) state == S_VECTOR && !nmi_pend && !pin_rise[res_idx[2:0]] && !res_idx[3] |=> !pending[$past(res_idx)];
	endproperty
	a_vector_clears: assert property (p_vector_clears) else $error("flag not cleared");

	property p_set_mask_zero;
		@(posedge CLOCK) disable iff (RST) cmd_commit && cmd_op == OP_SET_MASK && cmd_arg == 3'h0 |=> mask_level == 3'h1;
	endproperty
	a_set_mask_zero: assert property (p_set_mask_zero) else $error("zero operand not one");

	property p_dma_end;
		@(posedge CLOCK) disable iff (RST) state == S_DMA && ch_count[acc_ch] == 16'h0001 |=> ch_vec[$past(acc_ch)] == 8'h00 ##1 pending[8 + $past(acc_ch, 2)];
	endproperty
	a_dma_end: assert property (p_dma_end) else $error("transfer end missing");

	property p_fetch_addr;
		@(posedge CLOCK) disable iff (RST) HANDLER_START |-> VECTOR_FETCH_ADDR[23:8] == 16'hffff && VECTOR_FETCH_ADDR[7:0] == $past(acc_vec);
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("wrong fetch address");
endmodule

// ==== testbench/request_source.sv ====
// far-side model raising the external request and non-maskable pins
`timescale 1ns/1ps
module request_source (
	input wire logic clock,
	input wire logic [8:0] fire,
	output logic [7:0] pins,
	output logic nmi
);
	logic [3:0] hold;
	initial begin
		pins = 8'h00;
		nmi = 1'b0;
		hold = 4'h0;
	end
	// one line per source, eight pins plus one non-maskable
	// held long enough to pass the input filter, then back to idle low
	always @(posedge clock) begin
		if (fire != 9'h000) begin
			pins <= pins | fire[7:0];
			nmi <= nmi | fire[8];
			hold <= 4'hf;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end else begin
			pins <= 8'h00;
			nmi <= 1'b0;
		end
	end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the interrupt acceptance block
`timescale 1ns/1ps
module tb;
	import intc_pkg::*;
	typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
	logic CLOCK, RST, READ, WRITE, WAITREQUEST, HANDLER_START, NMI_PIN;
	logic [8:0] ADDRESS, fire;
	logic [31:0] WRITEDATA, READDATA;
	logic [7:0] EXTERNAL_REQUEST_PINS;
	logic [2:0] PRESENT_LEVEL;
	logic DMA_XFER;
	logic [2:0] DMA_CHANNEL, DMA_BYTES;
	logic [5:0] dq[$];
	logic [23:0] VECTOR_FETCH_ADDR, HANDLER_PC;
	logic [23:0] ha [256];
	note_t rq[$];
	logic [7:0] hq[$];
	int err_total = 0;
	int n_compared = 0;
	priority_interrupt_acceptance u_dut (.CLOCK, .RST, .ADDRESS, .READ,
		.WRITE, .WRITEDATA, .READDATA, .WAITREQUEST, .EXTERNAL_REQUEST_PINS,
		.NMI_PIN, .PRESENT_LEVEL, .HANDLER_START, .VECTOR_FETCH_ADDR,
		.HANDLER_PC, .DMA_XFER, .DMA_CHANNEL, .DMA_BYTES);
	request_source u_src (.clock(CLOCK), .fire(fire),
		.pins(EXTERNAL_REQUEST_PINS), .nmi(NMI_PIN));
	initial begin
		CLOCK = 1'b0;
		forever #10 CLOCK = ~CLOCK;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (e !== s) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		ADDRESS <= a;
		WRITE <= w;
		READ <= !w;
		WRITEDATA <= d;
		// waitrequest is sampled at the rising edge, before it moves
		do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
		READ <= 1'b0;
		WRITE <= 1'b0;
	endtask
	task automatic st(input logic [2:0] mask, input logic [7:0] nest);
		rq.push_back('{{16'h0, nest, 5'h0, mask}, 32'h0000ff07});
		bus(1'b0, ADDR_CMD, 32'h0);
	endtask
	task automatic cmd(input cmd_op_t op, input logic [2:0] arg);
		bus(1'b1, ADDR_CMD, {25'h0, op, 1'b0, arg});
	endtask
	task automatic pulse(input logic [8:0] v);
		@(posedge CLOCK);
		fire <= v;
		@(posedge CLOCK);
		fire <= 9'h000;
	endtask
	task automatic wait_start;
		for (int i = 0; i < 200 && hq.size() + dq.size() != 0; i++) @(posedge CLOCK);
		if (hq.size() + dq.size() != 0) begin
			$display("mismatch queue expected 0 seen %0d", hq.size() + dq.size());
			err_total++;
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// result monitors
	// ----------------------------------------
	// read data taken at the edge that sees waitrequest low
	always @(posedge CLOCK) begin
		note_t n;
		if (READ === 1'b1 && WAITREQUEST === 1'b0) begin
			n = rq.pop_front();
			chk("status", n.e, READDATA & n.m);
		end
	end
	always @(negedge CLOCK) begin
		if (HANDLER_START === 1'b1) begin
			// an entry nobody expected means a blocked source got through
			if (hq.size() == 0) begin
				chk("unexpected_start", 32'h0, 32'h1);
			end else begin
				chk("fetch", {8'h0, VECTOR_BASE + hq[0]}, {8'h0, VECTOR_FETCH_ADDR});
				chk("handler", {8'h0, ha[hq[0]]}, {8'h0, HANDLER_PC});
				void'(hq.pop_front());
			end
		end
		if (DMA_XFER === 1'b1) begin
			// a transfer after the count ran out means the channel stayed armed
			if (dq.size() == 0) begin
				chk("unexpected_transfer", 32'h0, 32'h1);
			end else begin
				chk("transfer", {26'h0, dq[0]}, {26'h0, DMA_CHANNEL, DMA_BYTES});
				void'(dq.pop_front());
			end
		end
	end
	initial begin
		repeat (20000) @(posedge CLOCK);
		err_total++;
		test_done();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] vs [5];
		vs = '{8'h2c, 8'h30, VEC_NMI, VEC_ILLEGAL, 8'hdc};
		RST = 1'b1;
		READ = 1'b0;
		WRITE = 1'b0;
		ADDRESS = 9'h000;
		WRITEDATA = 32'h0;
		fire = 9'h000;
		void'($urandom(32'hbc3c));
		repeat (8) @(posedge CLOCK);
		RST <= 1'b0;
		st(3'h7, 8'h00);
		foreach (vs[i]) begin
			ha[vs[i]] = 24'($urandom());
			bus(1'b1, ADDR_VTAB + {1'b0, vs[i]}, {8'h0, ha[vs[i]]});
		end
		cmd(OP_SET_MASK, 3'h0);
		st(3'h1, 8'h00);
		cmd(OP_BLOCK_MASKABLE, 3'h0);
		st(3'h7, 8'h00);
		// pins 1 and 2 at level 4, pin 5 left at level 0
		bus(1'b1, ADDR_PRIO_PIN, 32'h00000440);
		pulse(9'h026);
		repeat (20) @(posedge CLOCK);
		hq.push_back(8'h2c);
		cmd(OP_SET_MASK, 3'h0);
		wait_start();
		st(3'h5, 8'h01);
		// no entry while the handler's first instruction is outstanding
		pulse(9'h100);
		repeat (20) @(posedge CLOCK);
		hq.push_back(VEC_NMI);
		cmd(OP_STEP, 3'h0);
		wait_start();
		st(3'h7, 8'h02);
		cmd(OP_RETURN, 3'h0);
		st(3'h5, 8'h01);
		hq.push_back(8'h30);
		cmd(OP_RETURN, 3'h0);
		wait_start();
		st(3'h5, 8'h01);
		cmd(OP_RETURN, 3'h0);
		cmd(OP_BLOCK_MASKABLE, 3'h0);
		hq.push_back(VEC_ILLEGAL);
		cmd(OP_ILLEGAL, 3'h0);
		wait_start();
		st(3'h7, 8'h01);
		cmd(OP_RETURN, 3'h0);
		// channel 3 moves 2-byte units on pin 6, two units
		bus(1'b1, ADDR_CH_BASE + 9'h00c, 32'h00020140);
		bus(1'b1, ADDR_PRIO_TC, 32'h00003000);
		pulse(9'h040);
		repeat (30) @(posedge CLOCK);
		chk("present", 32'h6, {29'h0, PRESENT_LEVEL});
		dq.push_back({3'h3, 3'h2});
		cmd(OP_SET_MASK, 3'h6);
		wait_start();
		dq.push_back({3'h3, 3'h2});
		pulse(9'h040);
		repeat (30) @(posedge CLOCK);
		// channel is disarmed now, so a further edge moves nothing
		pulse(9'h040);
		repeat (30) @(posedge CLOCK);
		hq.push_back(8'hdc);
		cmd(OP_SET_MASK, 3'h3);
		wait_start();
		cmd(OP_STEP, 3'h0);
		dq.push_back({3'h2, 3'h1});
		dq.push_back({3'h5, 3'h1});
		bus(1'b1, ADDR_SOFT_DMA, 32'h00000024);
		wait_start();
		repeat (20) @(posedge CLOCK);
		test_done();
	end
endmodule
